// ==== rtl/multilevel_interrupt_priority.sv ====
// Contract
// R1: Three priority levels low, high and top are supported for nested service.
// R2: A request whose level is not above the level in service is not accepted.
// R3: Among pending vectors the one with the highest level is granted.
// R4: Among equal levels the vector with the smallest address is granted.
// R5: Sixteen sources map onto nine vectors, some sources sharing a vector.
// R6: Level comparison orders top above high above low.
// R7: A grant is held until the core acknowledges, and return restores the prior level; the code ignores irq_ret while irq_pend is high.
`timescale 1ns/1ps
module multilevel_interrupt_priority #(
  parameter int NSRC = irq_prio_pkg::NUM_SRC
) (
  input  wire logic              clk_sys,    // System clock
  input  wire logic              sys_rst,    // Async reset, active high
  input  wire logic [NSRC-1:0]   src_req,    // Source request levels
  input  wire logic [NSRC-1:0]   src_hi,     // Source set to high level
  input  wire logic [NSRC-1:0]   src_top,    // Source set to top level
  input  wire logic              vec_ack,    // Core takes the vector
  input  wire logic              irq_ret,    // Core returns from handler
  output logic                   irq_pend,   // Vector request to core
  output logic [19:0]            irq_addr,   // Vector address
  output logic [3:0]             irq_vec,    // Vector index
  output logic [1:0]             irq_lvl,    // Level of offered vector
  output logic [1:0]             serv_lvl    // Level now in service
);
  localparam int NV = irq_prio_pkg::NUM_VEC;

  logic [NV-1:0]   vreq;
  logic [2*NV-1:0] vlvl;
  logic            wv;
  logic [3:0]      wi;
  logic [1:0]      wl;
  logic [1:0]      slvl [NSRC];

  // Per-source level; top asked on a vector that lacks it falls back to high
  for (genvar s = 0; s < NSRC; s++) begin : g_src
    always_comb begin
      if (!src_req[s]) begin
        slvl[s] = irq_prio_pkg::LVL_NONE;
      end else if (src_top[s] && irq_prio_pkg::TOP_OK[irq_prio_pkg::SRC_VEC[s]]) begin
        slvl[s] = irq_prio_pkg::LVL_TOP; // R1
      end else if (src_hi[s] || src_top[s]) begin
        slvl[s] = irq_prio_pkg::LVL_HIGH;
      end else begin
        slvl[s] = irq_prio_pkg::LVL_LOW;
      end
    end

    src_map_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R5
      src_req[s] |-> vreq[irq_prio_pkg::SRC_VEC[s]])
      else $error("source not seen on its vector");
  end

  // A vector pends when any of its sources does and takes their top level
  always_comb begin
    vreq = '0;
    vlvl = '0;
    for (int s = 0; s < NSRC; s++) begin
      if (slvl[s] != irq_prio_pkg::LVL_NONE) begin // R5
        vreq[irq_prio_pkg::SRC_VEC[s]] = 1'b1;
        if (slvl[s] > vlvl[2*irq_prio_pkg::SRC_VEC[s] +: 2]) begin
          vlvl[2*irq_prio_pkg::SRC_VEC[s] +: 2] = slvl[s]; // R6
        end
      end
    end
  end

  irq_vec_arbiter #(.NVEC(NV)) u_arb (
    .vec_req   (vreq),
    .vec_lvl   (vlvl),
    .win_valid (wv),
    .win_idx   (wi),
    .win_lvl   (wl)
  );

  // Stack of outer levels, deep enough for three nested levels
  logic [1:0] stk_r [3];
  logic [1:0] stk_nxt [3];
  logic [1:0] dep_r;
  logic [1:0] dep_nxt;
  logic [1:0] serv_nxt;
  logic [1:0] lvl_nxt;
  logic       pend_nxt;
  logic [3:0] vec_nxt;
  logic [19:0] addr_nxt;

  always_comb begin
    stk_nxt  = stk_r;
    dep_nxt  = dep_r;
    serv_nxt = serv_lvl;
    pend_nxt = irq_pend;
    vec_nxt  = irq_vec;
    lvl_nxt  = irq_lvl;
    addr_nxt = irq_addr;
    if (irq_pend) begin
      if (vec_ack) begin // R7
        stk_nxt[dep_r] = serv_lvl;
        dep_nxt  = dep_r + 2'h1;
        serv_nxt = irq_lvl;
        pend_nxt = 1'b0;
      end
    end else if (irq_ret && dep_r != 2'h0) begin
      serv_nxt = stk_r[dep_r - 2'h1]; // R7
      dep_nxt  = dep_r - 2'h1;
    end else if (wv && wl > serv_lvl) begin // R2
      pend_nxt = 1'b1;
      vec_nxt  = wi;
      lvl_nxt  = wl;
      addr_nxt = irq_prio_pkg::VEC_ADDR[wi];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      stk_r    <= '{default: irq_prio_pkg::RST_LEVEL};
      dep_r    <= irq_prio_pkg::RST_DEPTH;
      serv_lvl <= irq_prio_pkg::RST_LEVEL;
      irq_pend <= 1'b0;
      irq_vec  <= 4'h0;
      irq_lvl  <= irq_prio_pkg::RST_LEVEL;
      irq_addr <= 20'h00000;
    end else begin
      stk_r    <= stk_nxt;
      dep_r    <= dep_nxt;
      serv_lvl <= serv_nxt;
      irq_pend <= pend_nxt;
      irq_vec  <= vec_nxt;
      irq_lvl  <= lvl_nxt;
      irq_addr <= addr_nxt;
    end
  end

  // Grant side
  no_lower_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R2
    $rose(irq_pend) |-> irq_lvl > serv_lvl)
    else $error("grant not above service level");
  wait_refuse_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R2
    !irq_pend && !irq_ret && !(wv && wl > serv_lvl) |=> !irq_pend)
    else $error("request at or below service level granted");
  hold_grant_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
    irq_pend && !vec_ack |=> irq_pend && $stable(irq_vec))
    else $error("grant dropped");
  hold_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
    irq_pend && !vec_ack |=> $stable(irq_addr) && $stable(irq_lvl))
    else $error("offered vector changed");
  top_wins_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R3
    !irq_pend && !irq_ret && wv && wl > serv_lvl |=> irq_lvl == $past(wl) && irq_pend)
    else $error("highest level not granted");
  pend_win_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R3
    $rose(irq_pend) |-> irq_vec == $past(wi) && irq_lvl == $past(wl))
    else $error("offered vector is not the winner");
  no_win_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R3
    vreq == '0 |-> !wv)
    else $error("winner without request");
  addr_map_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R5
    irq_pend |-> irq_addr == irq_prio_pkg::VEC_ADDR[irq_vec])
    else $error("vector address wrong");
  vec_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R5
    irq_pend |-> irq_vec < 4'(NV))
    else $error("vector index out of range");
  top_vec_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R5
    irq_pend && irq_lvl == irq_prio_pkg::LVL_TOP |-> irq_prio_pkg::TOP_OK[irq_vec])
    else $error("top level on a vector without it");
  tie_small_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R4
    wv |-> !(vreq[0] && vlvl[1:0] == wl) || wi == 4'h0)
    else $error("tie not smallest");
  order_lvl_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R6
    wv && vreq[0] && vlvl[1:0] == irq_prio_pkg::LVL_TOP |-> wl == irq_prio_pkg::LVL_TOP)
    else $error("top not above high");
  three_lvl_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
    irq_pend |-> irq_lvl != irq_prio_pkg::LVL_NONE)
    else $error("bad level");

  // Service level and nesting
  ack_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
    irq_pend && vec_ack |=> serv_lvl == $past(irq_lvl) && !irq_pend)
    else $error("service level not taken");
  ack_raise_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R2
    irq_pend && vec_ack |=> serv_lvl > $past(serv_lvl))
    else $error("nesting did not raise the level");
  depth_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
    irq_pend && vec_ack |=> dep_r == $past(dep_r) + 2'h1)
    else $error("nest depth not pushed");
  nest_ret_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
    irq_pend && vec_ack ##1 (!irq_pend && irq_ret && dep_r != 2'h0)
    |=> serv_lvl == $past(serv_lvl, 2))
    else $error("level not restored");
  ret_lower_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
    !irq_pend && irq_ret && dep_r != 2'h0 |=> serv_lvl < $past(serv_lvl))
    else $error("return did not lower the level");
  ret_first_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
    !irq_pend && irq_ret |=> !irq_pend)
    else $error("grant beat a return");
  serv_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
    !irq_pend && !irq_ret |=> $stable(serv_lvl))
    else $error("service level moved without cause");
  idle_none_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
    dep_r == 2'h0 |-> serv_lvl == irq_prio_pkg::LVL_NONE)
    else $error("level in service with empty stack");
  full_top_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
    dep_r == 2'h3 |-> serv_lvl == irq_prio_pkg::LVL_TOP)
    else $error("three deep but not at top level");

  // Every pending vector is weighed against the winner
  for (genvar v = 0; v < NV; v++) begin : g_vchk
    no_higher_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R3
      vreq[v] |-> wv && wl >= vlvl[2*v +: 2])
      else $error("pending vector above winner");
    tie_lowest_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R4
      vreq[v] && vlvl[2*v +: 2] == wl |-> wi <= 4'(v))
      else $error("tie not taken by smaller vector");
    clip_top_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
      !irq_prio_pkg::TOP_OK[v] |-> vlvl[2*v +: 2] != irq_prio_pkg::LVL_TOP)
      else $error("top level on a vector without it");
  end

endmodule

// ==== rtl/irq_prio_pkg.sv ====
package irq_prio_pkg;
  localparam int NUM_SRC = 16;
  localparam int NUM_VEC = 9;
  localparam int VEC_W   = 4;
  localparam int STK_W   = 2;

  // Level coding: ordered so plain numeric compare gives highest > high > low
  typedef enum logic [1:0] {
    LVL_NONE = 2'h0,
    LVL_LOW  = 2'h1,
    LVL_HIGH = 2'h2,
    LVL_TOP  = 2'h3
  } level_t;

  // Vector addresses in ascending order; index 0 is the smallest
  localparam logic [19:0] VEC_ADDR [NUM_VEC] = '{
    20'h00003, 20'h0000B, 20'h00013, 20'h0001B, 20'h00023,
    20'h0002B, 20'h0003B, 20'h00043, 20'h0004B
  };

  // Source to vector index map (16 sources onto 9 vectors)
  localparam logic [3:0] SRC_VEC [NUM_SRC] = '{
    4'h0, 4'h0, 4'h1, 4'h2, 4'h2, 4'h2, 4'h2, 4'h3,
    4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'h8
  };

  // Top level is allowed on the first two vectors only, others clip to high
  localparam logic [NUM_VEC-1:0] TOP_OK = 9'h003;
  localparam logic [1:0] RST_LEVEL = 2'h0;
  localparam logic [1:0] RST_DEPTH = 2'h0;
endpackage

// ==== rtl/irq_vec_arbiter.sv ====
`timescale 1ns/1ps
module irq_vec_arbiter #(
  parameter int NVEC = irq_prio_pkg::NUM_VEC
) (
  input  wire logic [NVEC-1:0]   vec_req,   // Pending per vector
  input  wire logic [2*NVEC-1:0] vec_lvl,   // Level per vector
  output logic                   win_valid, // Some vector wins
  output logic [3:0]             win_idx,   // Winning vector index
  output logic [1:0]             win_lvl    // Winning level
);
  always_comb begin
    win_valid = 1'b0;
    win_idx   = 4'h0;
    win_lvl   = 2'h0;
    // Descending scan so the smallest index wins ties
    for (int i = NVEC - 1; i >= 0; i--) begin
      if (vec_req[i] && (vec_lvl[2*i +: 2] >= win_lvl)) begin // R3 R4 R6
        win_valid = 1'b1;
        win_idx   = 4'(i);
        win_lvl   = vec_lvl[2*i +: 2];
      end
    end
  end
endmodule

// ==== sim/core_model.sv ====
`timescale 1ns/1ps
module core_model (
  input  wire logic       clk_sys,  // System clock
  input  wire logic       sys_rst,  // Reset
  input  wire logic       irq_pend, // Vector offered
  input  wire logic [1:0] ack_dly,  // Cycles before taking it
  output logic            vec_ack   // Take pulse
);
  int cnt;
  initial vec_ack = 1'b0;
  always @(negedge clk_sys) begin
    if (sys_rst || !irq_pend || vec_ack) begin
      cnt = 0;
      vec_ack <= 1'b0;
    end else if (cnt >= ack_dly) begin
      vec_ack <= 1'b1;
    end else begin
      cnt++;
    end
  end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] src_req = 16'h0000, src_hi = 16'h0000, src_top = 16'h0000;
  logic        vec_ack, irq_ret = 1'b0, irq_pend;
  logic [19:0] irq_addr;
  logic [3:0]  irq_vec;
  logic [1:0]  irq_lvl, serv_lvl, ack_dly = 2'h0;
  logic [5:0]  e;
  int          num_errors = 0, n_checks = 0, seed = 52529;
  always #50 clk_sys = ~clk_sys;
  multilevel_interrupt_priority dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .src_req(src_req),
    .src_hi(src_hi), .src_top(src_top), .vec_ack(vec_ack), .irq_ret(irq_ret),
    .irq_pend(irq_pend), .irq_addr(irq_addr), .irq_vec(irq_vec), .irq_lvl(irq_lvl),
    .serv_lvl(serv_lvl));
  core_model core (.clk_sys(clk_sys), .sys_rst(sys_rst), .irq_pend(irq_pend),
    .ack_dly(ack_dly), .vec_ack(vec_ack));
  // Winner as {level, vector}: highest level, then smallest vector
  function automatic logic [5:0] expect_win(logic [15:0] r, h, t);
    logic [1:0] vl [9];
    logic [1:0] l;
    logic [5:0] w;
    foreach (vl[v]) vl[v] = 2'h0;
    for (int s = 0; s < 16; s++) begin
      l = (t[s] && irq_prio_pkg::SRC_VEC[s] < 2) ? 2'h3 : (h[s] | t[s]) ? 2'h2 : 2'h1;
      if (r[s] && l > vl[irq_prio_pkg::SRC_VEC[s]]) vl[irq_prio_pkg::SRC_VEC[s]] = l;
    end
    w = 6'h00;
    for (int v = 0; v < 9; v++) if (vl[v] > w[5:4]) w = {vl[v], v[3:0]};
    return w;
  endfunction
  task automatic check(logic [19:0] seen, logic [19:0] expd);
    n_checks++;
    if (seen !== expd) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic ret(logic [1:0] expd);
    irq_ret = 1'b1;
    @(negedge clk_sys);
    irq_ret = 1'b0;
    @(negedge clk_sys);
    check(serv_lvl, expd);
  endtask
  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    for (int i = 0; i < 40; i++) begin
      check(irq_addr, 20'h00000);
      check({irq_pend, irq_vec, irq_lvl, serv_lvl}, 20'h00000);
      sys_rst = 1'b0;
      src_req = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h8000 : $random(seed);
      if (src_req == 16'h0000) src_req = 16'h0200;
      src_hi = (i < 2) ? 16'h0000 : $random(seed);
      src_top = (i < 2) ? 16'h0000 : $random(seed);
      ack_dly = $random(seed);
      e = expect_win(src_req, src_hi, src_top);
      repeat (20) if (!irq_pend) @(negedge clk_sys);
      check({irq_lvl, irq_vec}, e);
      check(irq_addr, irq_prio_pkg::VEC_ADDR[e[3:0]]);
      repeat (20) if (irq_pend) @(negedge clk_sys);
      repeat (3) @(negedge clk_sys);
      check(serv_lvl, e[5:4]);
      check(irq_pend, 1'b0);
      src_req[0] = 1'b1;
      src_top[0] = 1'b1;
      repeat (20) if (serv_lvl !== 2'h3) @(negedge clk_sys);
      check(serv_lvl, 2'h3);
      src_req = 16'h0000;
      ret((e[5:4] == 2'h3) ? 2'h0 : e[5:4]);
      ret(2'h0);
      sys_rst = 1'b1;
      @(negedge clk_sys);
    end
    finish_test();
  end
endmodule
